// file: core/spv_defs.vh
`ifndef SPV_DEFS_VH
`define SPV_DEFS_VH

// ********************************************************************
// Time base
// ********************************************************************
`define SPV_CLK_PERIOD_PS 4000
`define SPV_TICK_PERIOD_US 1000
`define SPV_TICK_CYCLES ((`SPV_TICK_PERIOD_US * 1000000) / `SPV_CLK_PERIOD_PS)
`define SPV_SETTLE_COUNT 2'h3

// ********************************************************************
// Supervisor intervals
// ********************************************************************
`define SPV_RESET_PULSE_WIDTH_MS 200
`define SPV_WATCHDOG_TIMEOUT_MS 1600
`define SPV_RESET_PULSE_TICKS ((`SPV_RESET_PULSE_WIDTH_MS * 1000) / `SPV_TICK_PERIOD_US)
`define SPV_WATCHDOG_TICKS ((`SPV_WATCHDOG_TIMEOUT_MS * 1000) / `SPV_TICK_PERIOD_US)

// ********************************************************************
// Watchdog input levels
// ********************************************************************
`define SPV_WDI_FLOAT 2'h0
`define SPV_WDI_LOW 2'h1
`define SPV_WDI_HIGH 2'h2

// ********************************************************************
// Reset cause codes and reset values
// ********************************************************************
`define SPV_CAUSE_NONE 2'h0
`define SPV_CAUSE_SUPPLY 2'h1
`define SPV_CAUSE_WATCHDOG 2'h2
`define SPV_CAUSE_BACKUP 2'h3
`define SPV_RST_RESET_ACTIVE 1'h1
`define SPV_RST_PFO_N 1'h0
`define SPV_RST_BACKUP 1'h0

`endif

// file: core/spv_sync.v
// ********************************************************************
// Two-stage synchroniser, one chain per bit
// ********************************************************************
module spv_sync #(
    parameter WIDTH = 6
) (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1)
        begin : g_bit
            reg meta;
            reg stable;
            always @(posedge i_clk_sys or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end
                else
                begin
                    meta <= i_async[gi];
                    stable <= meta;
                end
            end
            assign o_sync[gi] = stable;
        end
    endgenerate

endmodule // spv_sync

// file: core/spv_tick.v
// ********************************************************************
// Free-running time base, one-cycle tick every CYCLES clocks
// ********************************************************************
module spv_tick #(
    parameter integer CYCLES = 250000,
    parameter integer WIDTH = 18
) (
    input wire i_clk_sys,
    input wire i_rstn,
    output reg o_tick
);

    localparam integer LAST_I = CYCLES - 1;
    localparam [WIDTH-1:0] LAST = LAST_I[WIDTH-1:0];

    reg [WIDTH-1:0] cnt;

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cnt <= {WIDTH{1'b0}};
            o_tick <= 1'b0;
        end
        else
        begin
            o_tick <= (cnt == LAST);
            if (cnt == LAST)
                cnt <= {WIDTH{1'b0}};
            else
                cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule // spv_tick

// file: core/spv_supervisor.v
// Notes on behaviour
// - After supply rises above threshold, hold reset for the full pulse width.
// - Supply below threshold asserts reset; every trigger yields a full pulse width.
// - Brownout during a running pulse restarts the pulse from its start.
// - Watchdog input steady beyond the timeout triggers one reset pulse.
// - Watchdog timer stays cleared and stopped while reset is asserted.
// - Timing resumes at release; processor must toggle within the timeout.
// - Watchdog input decodes high, low or floating; floating disables the watchdog.
// - Floating keeps the timer clear; counting starts once released and driven.
// - Any level change of the watchdog input restarts the timeout.
// - Active-high reset output is always the inverse of the active-low one.
// - Power-fail output low when sense input is below reference, else high.
// - Backup mode forces the power-fail output low regardless of sense input.
// - Backup mode only when supply is below threshold and below backup supply.
// - Supply above threshold selects main supply and never enters backup.
// - Switchover uses the 20 mV up and 20 mV down comparator decisions.
// - Backup mode disables the watchdog and keeps reset asserted.
// - After supply falls below threshold, reset stays asserted continuously.
// - Pulse width 140 to 280 ms; timeout 1.00 to 2.25 s.
`include "spv_defs.vh"

module spv_supervisor #(
    parameter integer TICK_CYCLES = `SPV_TICK_CYCLES,
    parameter integer TICK_WIDTH = 18,
    parameter integer RESET_PULSE_TICKS = `SPV_RESET_PULSE_TICKS,
    parameter integer WATCHDOG_TICKS = `SPV_WATCHDOG_TICKS,
    parameter integer PULSE_WIDTH = 9,
    parameter integer WD_WIDTH = 11
) (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_supply_below_threshold,
    input wire i_backup_above_supply,
    input wire i_supply_above_backup,
    input wire i_power_fail_sense_below_ref,
    input wire i_watchdog_service_high,
    input wire i_watchdog_service_low,
    output reg o_reset_n,
    output reg o_reset,
    output reg o_power_fail_warning_n,
    output reg o_switched_supply_from_backup,
    output reg o_backup_mode,
    output reg o_watchdog_running,
    output reg [1:0] o_reset_cause
);

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam [1:0] ST_SUPPLY_LOW = 2'h0;
    localparam [1:0] ST_PULSE = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;
    localparam [1:0] ST_BACKUP = 2'h3;

    localparam integer PULSE_I = RESET_PULSE_TICKS;
    localparam [PULSE_WIDTH-1:0] PULSE_LOAD = PULSE_I[PULSE_WIDTH-1:0];
    localparam [PULSE_WIDTH-1:0] PULSE_ONE = {{(PULSE_WIDTH-1){1'b0}}, 1'b1};
    localparam integer WD_LAST_I = WATCHDOG_TICKS - 1;
    localparam [WD_WIDTH-1:0] WD_LAST = WD_LAST_I[WD_WIDTH-1:0];
    localparam [WD_WIDTH-1:0] WD_ONE = {{(WD_WIDTH-1){1'b0}}, 1'b1};

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    wire [5:0] flags_sync;
    wire supply_low;
    wire backup_above;
    wire supply_above;
    wire pfi_low;
    wire wdi_high;
    wire wdi_low;

    // Analog decisions are asynchronous to the clock
    spv_sync #(
        .WIDTH(6)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_async({i_watchdog_service_low, i_watchdog_service_high, i_power_fail_sense_below_ref,
                  i_supply_above_backup, i_backup_above_supply, i_supply_below_threshold}),
        .o_sync(flags_sync)
    );

    assign supply_low = flags_sync[0];
    assign backup_above = flags_sync[1];
    assign supply_above = flags_sync[2];
    assign pfi_low = flags_sync[3];
    assign wdi_high = flags_sync[4];
    assign wdi_low = flags_sync[5];

    // ****************************************************************
    // Time base
    // ****************************************************************
    wire tick;

    spv_tick #(
        .CYCLES(TICK_CYCLES),
        .WIDTH(TICK_WIDTH)
    ) u_tick (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .o_tick(tick)
    );

    // ****************************************************************
    // Start-up settling
    // ****************************************************************
    reg [1:0] settle_cnt;
    wire settled;

    // Synchronisers leave reset reading supply good; wait for real samples
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            settle_cnt <= 2'h0;
        else if (!settled)
            settle_cnt <= settle_cnt + 2'h1;
    end

    assign settled = (settle_cnt == `SPV_SETTLE_COUNT);

    // ****************************************************************
    // Watchdog input decode
    // ****************************************************************
    reg [1:0] wdi_level;
    reg [1:0] wdi_prev;
    wire wdi_driven;
    wire wdi_service;

    // Both comparators set is not a legal level; treat as floating
    always @*
    begin
        if (wdi_high && !wdi_low)
            wdi_level = `SPV_WDI_HIGH;
        else if (wdi_low && !wdi_high)
            wdi_level = `SPV_WDI_LOW;
        else
            wdi_level = `SPV_WDI_FLOAT;
    end

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            wdi_prev <= `SPV_WDI_FLOAT;
        else
            wdi_prev <= wdi_level;
    end

    assign wdi_driven = (wdi_level != `SPV_WDI_FLOAT);
    // Short pulses survive: 50 ns spans more than two clock periods
    assign wdi_service = (wdi_level != wdi_prev);

    // ****************************************************************
    // Battery switchover
    // ****************************************************************
    reg backup_mode;
    reg next_backup_mode;
    wire switch_conflict;

    // Both decisions at once is no real supply state; holding avoids toggling
    assign switch_conflict = backup_above && supply_above;

    always @*
    begin
        if (!supply_low)
            next_backup_mode = 1'b0;
        else if (switch_conflict)
            next_backup_mode = backup_mode;
        else if (backup_mode)
            next_backup_mode = !supply_above;
        else
            next_backup_mode = backup_above;
    end

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            backup_mode <= `SPV_RST_BACKUP;
        else
            backup_mode <= next_backup_mode;
    end

    // ****************************************************************
    // Reset sequencer
    // ****************************************************************
    reg [1:0] state;
    reg [1:0] next_state;
    reg [PULSE_WIDTH-1:0] pulse_cnt;
    reg [PULSE_WIDTH-1:0] next_pulse_cnt;
    reg [WD_WIDTH-1:0] wd_cnt;
    reg [WD_WIDTH-1:0] next_wd_cnt;
    reg [1:0] cause;
    reg [1:0] next_cause;
    wire wd_enable;
    wire wd_expire;
    wire next_reset_active;

    // Only counts while released; backup never reaches ST_RUN
    assign wd_enable = (state == ST_RUN) && wdi_driven;
    assign wd_expire = wd_enable && tick && !wdi_service && (wd_cnt == WD_LAST);

    always @*
    begin
        next_state = state;
        next_pulse_cnt = pulse_cnt;
        next_cause = cause;
        case (state)
            ST_SUPPLY_LOW:
            begin
                // Held continuously while supply is low
                next_pulse_cnt = PULSE_LOAD;
                if (backup_mode)
                begin
                    next_state = ST_BACKUP;
                    next_cause = `SPV_CAUSE_BACKUP;
                end
                else if (!supply_low && settled)
                    next_state = ST_PULSE;
            end
            ST_PULSE:
            begin
                if (supply_low)
                begin
                    // Brownout restarts the full interval
                    next_state = ST_SUPPLY_LOW;
                    next_pulse_cnt = PULSE_LOAD;
                    next_cause = `SPV_CAUSE_SUPPLY;
                end
                else if (tick)
                begin
                    if (pulse_cnt <= PULSE_ONE)
                        next_state = ST_RUN;
                    else
                        next_pulse_cnt = pulse_cnt - PULSE_ONE;
                end
            end
            ST_RUN:
            begin
                if (supply_low)
                begin
                    next_state = ST_SUPPLY_LOW;
                    next_pulse_cnt = PULSE_LOAD;
                    next_cause = `SPV_CAUSE_SUPPLY;
                end
                else if (wd_expire)
                begin
                    next_state = ST_PULSE;
                    next_pulse_cnt = PULSE_LOAD;
                    next_cause = `SPV_CAUSE_WATCHDOG;
                end
            end
            ST_BACKUP:
            begin
                next_pulse_cnt = PULSE_LOAD;
                if (!backup_mode)
                begin
                    next_state = ST_SUPPLY_LOW;
                    next_cause = `SPV_CAUSE_SUPPLY;
                end
            end
            default:
            begin
                next_state = ST_SUPPLY_LOW;
                next_pulse_cnt = PULSE_LOAD;
                next_cause = `SPV_CAUSE_SUPPLY;
            end
        endcase
    end

    always @*
    begin
        if (!wd_enable || wdi_service)
            next_wd_cnt = {WD_WIDTH{1'b0}};
        else if (tick && (wd_cnt != WD_LAST))
            next_wd_cnt = wd_cnt + WD_ONE;
        else
            next_wd_cnt = wd_cnt;
    end

    assign next_reset_active = (next_state != ST_RUN);

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state <= ST_SUPPLY_LOW;
            pulse_cnt <= PULSE_LOAD;
            wd_cnt <= {WD_WIDTH{1'b0}};
            cause <= `SPV_CAUSE_SUPPLY;
        end
        else
        begin
            state <= next_state;
            pulse_cnt <= next_pulse_cnt;
            wd_cnt <= next_wd_cnt;
            cause <= next_cause;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_reset_n <= !`SPV_RST_RESET_ACTIVE;
            o_reset <= `SPV_RST_RESET_ACTIVE;
            o_power_fail_warning_n <= `SPV_RST_PFO_N;
            o_switched_supply_from_backup <= `SPV_RST_BACKUP;
            o_backup_mode <= `SPV_RST_BACKUP;
            o_watchdog_running <= 1'b0;
            o_reset_cause <= `SPV_CAUSE_SUPPLY;
        end
        else
        begin
            o_reset_n <= !next_reset_active;
            o_reset <= next_reset_active;
            // Comparator is off in backup to save battery
            o_power_fail_warning_n <= !pfi_low && !next_backup_mode;
            o_switched_supply_from_backup <= next_backup_mode;
            o_backup_mode <= next_backup_mode;
            o_watchdog_running <= (next_state == ST_RUN) && wdi_driven;
            o_reset_cause <= next_cause;
        end
    end

endmodule // spv_supervisor

// file: dv/spv_supervisor_chk.sv
module spv_supervisor_chk #(
    parameter integer TICK_CYCLES = 10,
    parameter integer RESET_PULSE_TICKS = 5,
    parameter integer WATCHDOG_TICKS = 8
) (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_supply_below_threshold,
    input wire i_backup_above_supply,
    input wire i_supply_above_backup,
    input wire i_power_fail_sense_below_ref,
    input wire i_watchdog_service_high,
    input wire i_watchdog_service_low,
    input wire o_reset_n,
    input wire o_reset,
    input wire o_power_fail_warning_n,
    input wire o_switched_supply_from_backup,
    input wire o_backup_mode,
    input wire o_watchdog_running,
    input wire [1:0] o_reset_cause
);
    timeunit 1ns;
    timeprecision 100ps;
    // Slack covers the synchroniser and the free tick phase
    localparam integer PMIN = (RESET_PULSE_TICKS - 1) * TICK_CYCLES;
    localparam integer PMAX = RESET_PULSE_TICKS * TICK_CYCLES + 6;
    localparam integer WMIN = (WATCHDOG_TICKS - 1) * TICK_CYCLES - 4;
    localparam integer WMAX = WATCHDOG_TICKS * TICK_CYCLES + 8;
    logic [15:0] low_cnt;
    logic [15:0] wd_cnt;
    logic [1:0] wd_lvl;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            low_cnt <= 16'h0000;
            wd_cnt <= 16'h0000;
            wd_lvl <= 2'h0;
        end
        else
        begin
            low_cnt <= (o_reset_n || i_supply_below_threshold) ? 16'h0000 : low_cnt + 16'h0001;
            wd_lvl <= {i_watchdog_service_high, i_watchdog_service_low};
            if (!o_watchdog_running || wd_lvl != {i_watchdog_service_high, i_watchdog_service_low})
                wd_cnt <= 16'h0000;
            else
                wd_cnt <= wd_cnt + 16'h0001;
        end
    end

    // ****************************************
    // Steady input sequences
    // ****************************************
    sequence s_sup_low;
        i_supply_below_threshold [*4];
    endsequence
    sequence s_sup_good;
        !i_supply_below_threshold [*4];
    endsequence
    sequence s_enter_backup;
        (i_supply_below_threshold && i_backup_above_supply && !i_supply_above_backup) [*4];
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    a_reset_inverse: assert property (o_reset == !o_reset_n)
        else $error("active high reset is not the inverse");
    a_supply_low_reset: assert property (s_sup_low |-> !o_reset_n && !o_watchdog_running)
        else $error("reset not held while supply low");
    a_pulse_width: assert property ($rose(o_reset_n) |-> $past(low_cnt) >= PMIN && $past(low_cnt) <= PMAX)
        else $error("reset pulse width out of range");
    a_pfo_follow: assert property (s_sup_good ##0 (i_power_fail_sense_below_ref [*4])
        |-> !o_power_fail_warning_n)
        else $error("power fail warning not low");
    a_pfo_high: assert property ((!i_power_fail_sense_below_ref && !o_backup_mode) [*4]
        |=> o_power_fail_warning_n || o_backup_mode)
        else $error("power fail warning not high");
    a_backup_outputs: assert property (o_backup_mode |-> !o_power_fail_warning_n && o_reset)
        else $error("backup mode outputs wrong");
    a_no_backup_good: assert property (s_sup_good |-> !o_backup_mode && !o_switched_supply_from_backup)
        else $error("backup entered with supply good");
    a_backup_enter: assert property (s_enter_backup |-> o_backup_mode && o_switched_supply_from_backup)
        else $error("backup mode not entered");
    a_wd_cleared: assert property (!o_reset_n |-> !o_watchdog_running)
        else $error("watchdog runs during reset");
    a_wd_float: assert property ((i_watchdog_service_high == i_watchdog_service_low) [*4]
        |-> !o_watchdog_running)
        else $error("watchdog runs with input floating");
    a_wd_bound: assert property (o_watchdog_running |-> wd_cnt <= WMAX)
        else $error("watchdog expiry late");
    a_wd_expiry: assert property ($fell(o_reset_n) && o_reset_cause == 2'h2 |-> $past(wd_cnt) >= WMIN)
        else $error("watchdog expiry early");
endmodule // spv_supervisor_chk

// file: dv/spv_cpu_model.sv
module spv_cpu_model (
    input wire i_clk_sys,
    input wire i_reset_n,
    input wire [2:0] i_mode,
    output logic o_wd_high,
    output logic o_wd_low
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] cnt;
    logic [1:0] lvl;

    initial
    begin
        o_wd_high = 1'b0;
        o_wd_low = 1'b0;
        cnt = 6'h00;
    end

    // Modes: 0 float, 1 high, 2 service, 3 both flags, 4 low
    // Mode and reset are taken at the edge, before the bench moves them
    always @(posedge i_clk_sys)
    begin
        case (i_mode)
            3'h1: lvl = 2'h2;
            // 13 cycles high is 52 ns, just over the shortest pulse
            3'h2: lvl = (i_reset_n && cnt < 6'h0d) ? 2'h2 : 2'h1;
            3'h3: lvl = 2'h3;
            3'h4: lvl = 2'h1;
            default: lvl = 2'h0;
        endcase
        #1;
        cnt <= (cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
        {o_wd_high, o_wd_low} <= lvl;
    end
endmodule // spv_cpu_model

// file: dv/test_spv_supervisor.sv
module test_spv_supervisor;
    timeunit 1ns;
    timeprecision 100ps;
    localparam integer T = 10;
    localparam integer P = 5;
    localparam integer W = 8;
    localparam integer PMIN = (P - 1) * T;
    localparam integer PMAX = P * T + 6;
    logic i_clk_sys, i_rstn, sup_low, bk_above, sup_above, pfs_below;
    logic o_reset_n, o_reset, o_pfo_n, o_sw, o_backup, o_run;
    logic [1:0] o_cause;
    logic wd_hi, wd_lo;
    logic [2:0] mode;
    int err_count = 0;
    int compares = 0;
    int n;

    spv_supervisor #(.TICK_CYCLES(T), .RESET_PULSE_TICKS(P), .WATCHDOG_TICKS(W)) uut (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_supply_below_threshold(sup_low),
        .i_backup_above_supply(bk_above), .i_supply_above_backup(sup_above),
        .i_power_fail_sense_below_ref(pfs_below), .i_watchdog_service_high(wd_hi),
        .i_watchdog_service_low(wd_lo), .o_reset_n(o_reset_n), .o_reset(o_reset),
        .o_power_fail_warning_n(o_pfo_n), .o_switched_supply_from_backup(o_sw),
        .o_backup_mode(o_backup), .o_watchdog_running(o_run), .o_reset_cause(o_cause));
    spv_cpu_model cpu (.i_clk_sys(i_clk_sys), .i_reset_n(o_reset_n), .i_mode(mode),
        .o_wd_high(wd_hi), .o_wd_low(wd_lo));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task automatic chk_len(input string what, input int v, input int lo, input int hi);
        chk(what, 16'h0001, {15'h0000, v >= lo && v <= hi});
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic wait_rst(input logic lvl, input int max, output int cnt);
        cnt = 0;
        while (o_reset_n !== lvl && cnt < max)
        begin
            step(1);
            cnt++;
        end
        if (cnt >= max)
        begin
            $display("ERROR wait_reset expected %h seen %h", lvl, o_reset_n);
            err_count++;
            end_sim;
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_powerup;
        step(5);
        sup_low = 1'b0;
        wait_rst(1'b1, 200, n);
        chk_len("powerup_width", n, PMIN, PMAX);
        chk("reset_high_out", 16'h0000, o_reset);
    endtask

    task automatic t_brownout;
        sup_low = 1'b1;
        step(6);
        sup_low = 1'b0;
        step(20);
        chk("mid_pulse", 16'h0000, o_reset_n);
        sup_low = 1'b1;
        step(3);
        sup_low = 1'b0;
        wait_rst(1'b1, 200, n);
        chk_len("restart_width", n, PMIN, PMAX);
    endtask

    task automatic t_pfo;
        pfs_below = 1'b0;
        step(4);
        chk("pfo_high", 16'h0001, o_pfo_n);
        pfs_below = 1'b1;
        step(4);
        chk("pfo_low", 16'h0000, o_pfo_n);
        pfs_below = 1'b0;
        step(4);
        chk("pfo_back", 16'h0001, o_pfo_n);
    endtask

    // Both decoded floats and then servicing with short pulses
    task automatic t_float_service;
        for (int i = 0; i < 3; i++)
        begin
            mode = (i == 0) ? 3'h0 : (i == 1) ? 3'h3 : 3'h2;
            step(3 * W * T);
            chk("no_wd_reset", 16'h0001, o_reset_n);
            chk("wd_running", {15'h0000, i == 2}, o_run);
        end
    endtask

    task automatic t_backup;
        {sup_low, bk_above, sup_above} = 3'h6;
        step(6);
        chk("bk_state", 16'h00cb, {o_backup, o_sw, o_pfo_n, o_reset_n, o_reset, o_run, o_cause});
        bk_above = 1'b0;
        step(6);
        chk("bk_hold", 16'h0001, o_backup);
        sup_above = 1'b1;
        step(6);
        chk("bk_leave", 16'h0001, {o_backup, o_sw, o_reset_n, o_cause});
        {bk_above, sup_above} = 2'h2;
        step(6);
        chk("bk_again", 16'h0001, o_backup);
        sup_low = 1'b0;
        step(6);
        chk("bk_off_good", 16'h0000, {o_backup, o_sw});
        wait_rst(1'b1, 200, n);
        chk_len("bk_pulse", n, PMIN - 6, PMAX);
        step(10);
        chk("no_bk_good", 16'h0000, {o_backup, o_sw});
        {bk_above, sup_above} = 2'h1;
    endtask

    // Float first so the driven level counts as the last service
    task automatic t_steady;
        for (int i = 0; i < 2; i++)
        begin
            mode = 3'h0;
            step(5);
            mode = (i == 0) ? 3'h1 : 3'h4;
            wait_rst(1'b0, W * T + 50, n);
            chk_len("wd_timeout", n, (W - 1) * T, W * T + 6);
            chk("wd_cause", 16'h0002, o_cause);
            wait_rst(1'b1, 200, n);
            chk_len("wd_pulse", n, PMIN, PMAX);
        end
    endtask

    initial
    begin
        i_rstn = 1'b0;
        {sup_low, bk_above, sup_above, pfs_below} = 4'h9;
        mode = 3'h0;
        repeat (20) @(posedge i_clk_sys);
        #1;
        i_rstn = 1'b1;
        t_powerup;
        t_brownout;
        t_pfo;
        t_float_service;
        t_backup;
        t_steady;
        end_sim;
    end
endmodule // test_spv_supervisor

bind spv_supervisor spv_supervisor_chk #(.TICK_CYCLES(TICK_CYCLES), .RESET_PULSE_TICKS(RESET_PULSE_TICKS),
    .WATCHDOG_TICKS(WATCHDOG_TICKS)) u_chk (.i_clk_sys, .i_rstn, .i_supply_below_threshold,
    .i_backup_above_supply, .i_supply_above_backup, .i_power_fail_sense_below_ref, .i_watchdog_service_high,
    .i_watchdog_service_low, .o_reset_n, .o_reset, .o_power_fail_warning_n, .o_switched_supply_from_backup,
    .o_backup_mode, .o_watchdog_running, .o_reset_cause);
